// [src/irq_cfg_pkg.sv]
// Shared constants for the interrupt enable and priority register block.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
package irq_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int REG_W = 16;
  localparam int PRI_W = 3;
  localparam int NUM_SRC = 23;
  localparam int SRC_W = 5;
  localparam int NUM_EN_REGS = 4;
  localparam int NUM_PRI_REGS = 3;
  // Sources 0..11 have their enable here and their priority outside;
  // sources 12..22 have their priority here and their enable outside.
  localparam int NUM_EN_LOCAL = 12;
  localparam int NUM_PRI_LOCAL = 11;
  localparam int NUM_EXT_EN = NUM_SRC - NUM_EN_LOCAL;
  localparam int NUM_EXT_PRI = NUM_EN_LOCAL;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] EN_ADDR [NUM_EN_REGS] = '{8'h00, 8'h04, 8'h08, 8'h0C};
  localparam logic [ADDR_W-1:0] PRI_ADDR [NUM_PRI_REGS] = '{8'h10, 8'h14, 8'h18};
  localparam logic [ADDR_W-1:0] FLAG_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h24;
  localparam logic [ADDR_W-1:0] REQ_STATE_ADDR = 8'h28;

  // Implemented bits of each register; all others read zero
  localparam logic [REG_W-1:0] EN_MASK [NUM_EN_REGS] = '{16'h0023, 16'h4006, 16'h210E, 16'h0001};
  localparam logic [REG_W-1:0] PRI_MASK [NUM_PRI_REGS] = '{16'h7777, 16'h7770, 16'h7777};
  localparam logic [REG_W-1:0] EN_RST = 16'h0000;
  localparam logic [REG_W-1:0] PRI_RST [NUM_PRI_REGS] = '{16'h4444, 16'h4440, 16'h4444};

  // Enable bit position per local-enable source (0..11)
  localparam int EN_REG_OF [NUM_EN_LOCAL] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 3};
  localparam int EN_BIT_OF [NUM_EN_LOCAL] = '{5, 1, 0, 14, 2, 1, 13, 8, 3, 2, 1, 0};
  // Priority field position per local-priority source (12..22)
  localparam int PRI_REG_OF [NUM_PRI_LOCAL] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
  localparam int PRI_LSB_OF [NUM_PRI_LOCAL] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0};

  localparam logic [PRI_W-1:0] PRI_DISABLED = 3'h0;

  // Interrupt status / mask bits
  localparam int NUM_ST = 2;
  localparam int ST_NEW_REQ = 0;
  localparam int ST_ACC_ERR = 1;

  // Request state register layout
  localparam int REQ_VALID_BIT = 0;
  localparam int REQ_LEVEL_LSB = 4;
  localparam int REQ_SRC_LSB = 8;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// [src/reg_access_if.sv]
// Register access strobes between the APB front end and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface reg_access_if;
  import irq_cfg_pkg::*;
  logic setup;
  logic wr_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] strb;
  logic [DATA_W-1:0] rdata;
  logic err;
  modport port (output setup, output wr_en, output addr, output wdata, output strb, input rdata, input err);
  modport regs (input setup, input wr_en, input addr, input wdata, input strb, output rdata, output err);
endinterface

// [src/apb_regport.sv]
// APB slave front end: one access cycle, registered answer.
// Assumes the register side decodes combinationally from the interface.
`timescale 1ns/100ps
module apb_regport
  import irq_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [STRB_W-1:0] i_pstrb,
  output logic o_pready,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  reg_access_if.port bus
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } port_state_t;

  port_state_t cur_reg;
  port_state_t cur_next;

  always_comb begin
    bus.setup = i_psel & ~i_penable;
    bus.wr_en = i_psel & i_penable & i_pwrite & cur_reg.pready;
    bus.addr = i_paddr;
    bus.wdata = i_pwdata;
    bus.strb = i_pstrb;
    cur_next = cur_reg;
    // Answer is prepared in the setup cycle so pready can come from a flop
    cur_next.pready = bus.setup;
    cur_next.pslverr = bus.setup & bus.err;
    if (bus.setup && !i_pwrite) begin
      cur_next.prdata = bus.rdata;
    end else if (bus.setup) begin
      cur_next.prdata = ZERO_WORD;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign o_pready = cur_reg.pready;
  assign o_prdata = cur_reg.prdata;
  assign o_pslverr = cur_reg.pslverr;

endmodule

// [src/request_arbiter.sv]
// Picks the highest-level pending request; ties go to the lowest source index.
// Assumes requests and levels come from logic on the same clock.
`timescale 1ns/100ps
module request_arbiter
  import irq_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [NUM_SRC-1:0] i_req,
  input wire logic [NUM_SRC-1:0][PRI_W-1:0] i_level,
  output logic o_valid,
  output logic [PRI_W-1:0] o_level,
  output logic [SRC_W-1:0] o_src
);

  typedef struct packed {
    logic valid;
    logic [PRI_W-1:0] level;
    logic [SRC_W-1:0] src;
  } arb_state_t;

  arb_state_t arb_reg;
  arb_state_t arb_next;

  always_comb begin
    arb_next = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Strict compare keeps the earlier source on equal levels
      if (i_req[i] && (i_level[i] > arb_next.level)) begin
        arb_next.valid = 1'b1;
        arb_next.level = i_level[i];
        arb_next.src = SRC_W'(i);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arb_reg <= '0;
    end else begin
      arb_reg <= arb_next;
    end
  end

  assign o_valid = arb_reg.valid;
  assign o_level = arb_reg.level;
  assign o_src = arb_reg.src;

endmodule

// [src/irq_enable_priority.sv]
// Interrupt enable and priority registers with source flags and request output.
// Assumes peripheral events and external enable/priority inputs share i_sys_clk.
`timescale 1ns/100ps

module irq_enable_priority
  import irq_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [STRB_W-1:0] i_pstrb,
  output logic o_pready,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  input wire logic [NUM_SRC-1:0] i_src_event,
  input wire logic [NUM_EXT_EN-1:0] i_ext_enable,
  input wire logic [NUM_EXT_PRI-1:0][PRI_W-1:0] i_ext_priority,
  output logic o_cpu_req,
  output logic [PRI_W-1:0] o_cpu_level,
  output logic [SRC_W-1:0] o_cpu_src,
  output logic o_irq
);

  typedef struct packed {
    logic [NUM_EN_REGS-1:0][REG_W-1:0] en;
    logic [NUM_PRI_REGS-1:0][REG_W-1:0] pri;
    logic [NUM_SRC-1:0] flag;
    logic [NUM_ST-1:0] status;
    logic [NUM_ST-1:0] mask;
    logic req_prev;
    logic irq;
  } regs_state_t;

  regs_state_t st_reg;
  regs_state_t st_next;

  reg_access_if bus ();

  logic [NUM_SRC-1:0] src_enable;
  logic [NUM_SRC-1:0][PRI_W-1:0] src_level;
  logic [NUM_SRC-1:0] src_req;
  logic arb_valid;
  logic [PRI_W-1:0] arb_level;
  logic [SRC_W-1:0] arb_src;
  logic hit;
  logic [DATA_W-1:0] lane;
  logic [DATA_W-1:0] req_word;
  logic [NUM_ST-1:0] st_events;

  // Only masked-in lanes change, so reserved bits stay at zero
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old_val,
    input logic [DATA_W-1:0] wd,
    input logic [DATA_W-1:0] lanes,
    input logic [REG_W-1:0] impl
  );
    logic [REG_W-1:0] sel;
    sel = lanes[REG_W-1:0] & impl;
    return (old_val & ~sel) | (wd[REG_W-1:0] & sel);
  endfunction

  apb_regport u_port (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_pready(o_pready),
    .o_prdata(o_prdata),
    .o_pslverr(o_pslverr),
    .bus(bus.port)
  );

  // Per-source enable and level, from this block or from outside
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    if (g < NUM_EN_LOCAL) begin : g_local_en
      assign src_enable[g] = st_reg.en[EN_REG_OF[g]][EN_BIT_OF[g]];
      assign src_level[g] = i_ext_priority[g];
    end else begin : g_local_pri
      assign src_enable[g] = i_ext_enable[g-NUM_EN_LOCAL];
      // Level equals the field code: 111 is 7, 001 is 1
      assign src_level[g] = st_reg.pri[PRI_REG_OF[g-NUM_EN_LOCAL]][PRI_LSB_OF[g-NUM_EN_LOCAL] +: PRI_W];
    end
    // A zero field blocks the source even with its enable set
    assign src_req[g] = st_reg.flag[g] & src_enable[g] & (src_level[g] != PRI_DISABLED);
  end

  request_arbiter u_arb (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_req(src_req),
    .i_level(src_level),
    .o_valid(arb_valid),
    .o_level(arb_level),
    .o_src(arb_src)
  );

  always_comb begin
    req_word = ZERO_WORD;
    req_word[REQ_VALID_BIT] = arb_valid;
    req_word[REQ_LEVEL_LSB +: PRI_W] = arb_level;
    req_word[REQ_SRC_LSB +: SRC_W] = arb_src;
  end

  always_comb begin
    st_next = st_reg;
    hit = 1'b0;
    bus.rdata = ZERO_WORD;
    lane = {{8{bus.strb[3]}}, {8{bus.strb[2]}}, {8{bus.strb[1]}}, {8{bus.strb[0]}}};
    for (int i = 0; i < NUM_EN_REGS; i++) begin
      if (bus.addr == EN_ADDR[i]) begin
        hit = 1'b1;
        bus.rdata[REG_W-1:0] = st_reg.en[i];
        if (bus.wr_en) begin
          st_next.en[i] = merge16(st_reg.en[i], bus.wdata, lane, EN_MASK[i]);
        end
      end
    end
    for (int i = 0; i < NUM_PRI_REGS; i++) begin
      if (bus.addr == PRI_ADDR[i]) begin
        hit = 1'b1;
        bus.rdata[REG_W-1:0] = st_reg.pri[i];
        if (bus.wr_en) begin
          st_next.pri[i] = merge16(st_reg.pri[i], bus.wdata, lane, PRI_MASK[i]);
        end
      end
    end
    case (bus.addr)
      FLAG_ADDR: begin
        hit = 1'b1;
        bus.rdata[NUM_SRC-1:0] = st_reg.flag;
        if (bus.wr_en) begin
          st_next.flag = (st_reg.flag & ~lane[NUM_SRC-1:0]) | (bus.wdata[NUM_SRC-1:0] & lane[NUM_SRC-1:0]);
        end
      end
      IRQ_STATUS_ADDR: begin
        hit = 1'b1;
        bus.rdata[NUM_ST-1:0] = st_reg.status;
        if (bus.wr_en && bus.strb[0]) begin
          st_next.status = st_reg.status & ~bus.wdata[NUM_ST-1:0];
        end
      end
      IRQ_MASK_ADDR: begin
        hit = 1'b1;
        bus.rdata[NUM_ST-1:0] = st_reg.mask;
        if (bus.wr_en && bus.strb[0]) begin
          st_next.mask = bus.wdata[NUM_ST-1:0];
        end
      end
      REQ_STATE_ADDR: begin
        hit = 1'b1;
        bus.rdata = req_word;
      end
      default: begin
      end
    endcase
    bus.err = ~hit;
    if (!hit) begin
      bus.rdata = ZERO_WORD;
    end
    // Hardware set wins over a same-cycle software clear
    st_next.flag = st_next.flag | i_src_event;
    st_events = '0;
    st_events[ST_NEW_REQ] = arb_valid & ~st_reg.req_prev;
    st_events[ST_ACC_ERR] = bus.setup & ~hit;
    st_next.status = st_next.status | st_events;
    st_next.req_prev = arb_valid;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg.en <= {NUM_EN_REGS{EN_RST}};
      st_reg.pri <= {PRI_RST[2], PRI_RST[1], PRI_RST[0]};
      st_reg.flag <= '0;
      st_reg.status <= '0;
      st_reg.mask <= '0;
      st_reg.req_prev <= 1'b0;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_cpu_req = arb_valid;
  assign o_cpu_level = arb_level;
  assign o_cpu_src = arb_src;
  assign o_irq = st_reg.irq;

endmodule

// [verification/irq_enable_priority_asserts.sv]
// Checker for the APB answer and the request outputs.
// Assumes it is bound to irq_enable_priority and sees only its ports.
`timescale 1ns/100ps
module irq_enable_priority_asserts
  import irq_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic o_pready,
  input wire logic [DATA_W-1:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_cpu_req,
  input wire logic [PRI_W-1:0] o_cpu_level,
  input wire logic [SRC_W-1:0] o_cpu_src
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  // Unmapped covers holes past the last register and misaligned bytes
  sequence bad_addr_s;
    setup_s ##0 (i_paddr > 8'h28 || i_paddr[1:0] != 2'h0);
  endsequence
  a_ready_after_setup: assert property (setup_s |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_ready_needs_setup: assert property (!i_psel |=> !o_pready)
    else $error("ready without transfer");
  a_err_on_unmapped: assert property (bad_addr_s |=> o_pslverr)
    else $error("no error on unmapped address");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error outside access");
  a_upper_half_zero: assert property (o_pready && !i_pwrite && i_paddr < 8'h1c |-> o_prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_level_nonzero: assert property (o_cpu_req |-> o_cpu_level != 3'h0)
    else $error("request at level zero");
  a_idle_zero: assert property (!o_cpu_req |-> o_cpu_level == 3'h0 && o_cpu_src == 5'h00)
    else $error("idle outputs not zero");
endmodule

bind irq_enable_priority irq_enable_priority_asserts i_irq_enable_priority_asserts (.i_sys_clk, .i_rst_n,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_prdata, .o_pslverr, .o_cpu_req, .o_cpu_level, .o_cpu_src);

// [verification/irq_source_model.sv]
// Peripheral event sources and the outside enable and priority settings.
// Assumes the bench commands it on the block's clock.
`timescale 1ns/100ps
module irq_source_model
  import irq_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_fire,
  input wire logic [SRC_W-1:0] i_src,
  input wire logic i_ext_en,
  input wire logic [PRI_W-1:0] i_ext_pri,
  output logic [NUM_SRC-1:0] o_src_event,
  output logic [NUM_EXT_EN-1:0] o_ext_enable,
  output logic [NUM_EXT_PRI-1:0][PRI_W-1:0] o_ext_priority
);
  // One pulse per commanded cycle, as a peripheral raises its event
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_src_event <= '0;
    end else begin
      o_src_event <= i_fire ? (NUM_SRC'(1) << i_src) : '0;
    end
  end
  assign o_ext_enable = {NUM_EXT_EN{i_ext_en}};
  assign o_ext_priority = {NUM_EXT_PRI{i_ext_pri}};
endmodule

// [verification/test_interrupt_enable_priority_regs.sv]
// Self-checking bench for the enable and priority registers.
// Assumes the source model beside the block; APB waits are bounded by the bench.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); bad_count++; end end
module test_interrupt_enable_priority_regs;
  import irq_cfg_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = 8'h00;
  logic [DATA_W-1:0] i_pwdata = 32'h0000_0000;
  logic [STRB_W-1:0] i_pstrb = 4'hf;
  logic fire = 1'b0;
  logic [SRC_W-1:0] src_sel = 5'h00;
  logic [PRI_W-1:0] ext_pri = 3'h5;
  logic o_pready, o_pslverr, o_cpu_req, o_irq, err;
  logic [DATA_W-1:0] o_prdata, rd;
  logic [PRI_W-1:0] o_cpu_level;
  logic [SRC_W-1:0] o_cpu_src;
  logic [NUM_SRC-1:0] i_src_event;
  logic [NUM_EXT_EN-1:0] i_ext_enable;
  logic [NUM_EXT_PRI-1:0][PRI_W-1:0] i_ext_priority;
  int bad_count = 0;
  int comparisons = 0;
  logic [15:0] impl [7] = '{16'h0023, 16'h4006, 16'h210e, 16'h0001, 16'h7777, 16'h7770, 16'h7777};
  int en_adr [12] = '{0, 0, 0, 4, 4, 4, 8, 8, 8, 8, 8, 12};
  int en_bit [12] = '{5, 1, 0, 14, 2, 1, 13, 8, 3, 2, 1, 0};
  int pri_lsb [11] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0};
  always #5 i_sys_clk = ~i_sys_clk;
  irq_enable_priority i_irq_enable_priority (.i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .i_src_event, .i_ext_enable, .i_ext_priority,
    .o_cpu_req, .o_cpu_level, .o_cpu_src, .o_irq);
  irq_source_model i_irq_source_model (.i_sys_clk, .i_rst_n, .i_fire(fire), .i_src(src_sel), .i_ext_en(1'b1),
    .i_ext_pri(ext_pri), .o_src_event(i_src_event), .o_ext_enable(i_ext_enable), .o_ext_priority(i_ext_priority));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Request holds until pready is seen high at a rising edge; data is taken at that same edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        bad_count++;
        give_verdict();
      end
      @(posedge i_sys_clk);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wait_sig(input logic on_irq, input logic exp);
    int n;
    n = 0;
    while ((on_irq ? o_irq : o_cpu_req) !== exp) begin
      n++;
      if (n > 8) begin
        bad_count++;
        give_verdict();
      end
      @(negedge i_sys_clk);
    end
  endtask
  task automatic fire_src(input int s);
    @(posedge i_sys_clk);
    fire <= 1'b1;
    src_sel <= 5'(s);
    @(posedge i_sys_clk);
    fire <= 1'b0;
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      `CHK("reset value", {16'h0000, i < 4 ? 16'h0000 : 16'h4444 & impl[i]}, rd)
      apb(1'b1, 8'(4 * i), 32'hffff_ffff);
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      `CHK("implemented bits", {16'h0000, impl[i]}, rd)
      `CHK("mapped error", 1'b0, err)
      apb(1'b1, 8'(4 * i), 32'h0000_0000);
    end
    $display("register test done");
  endtask
  task automatic t_priority();
    for (int k = 0; k < 11; k++) begin
      apb(1'b1, 8'(16 + 4 * (k > 3) + 4 * (k > 6)), 32'((k % 7 + 1) << pri_lsb[k]));
      fire_src(12 + k);
      wait_sig(1'b0, 1'b1);
      `CHK("request level", 3'(k % 7 + 1), o_cpu_level)
      `CHK("request source", 5'(12 + k), o_cpu_src)
      apb(1'b0, 8'h28, 32'h0000_0000);
      `CHK("request state", 32'(((12 + k) << 8) | ((k % 7 + 1) << 4) | 1), rd)
      apb(1'b1, 8'h1c, 32'h0000_0000);
      wait_sig(1'b0, 1'b0);
    end
    apb(1'b1, 8'h18, 32'h0000_0000);
    fire_src(22);
    repeat (4) @(negedge i_sys_clk);
    `CHK("disabled source", 1'b0, o_cpu_req)
    $display("priority test done");
  endtask
  task automatic t_enable();
    fire_src(0);
    repeat (4) @(negedge i_sys_clk);
    `CHK("blocked request", 1'b0, o_cpu_req)
    apb(1'b0, 8'h1c, 32'h0000_0000);
    `CHK("source flags", 32'h0040_0001, rd)
    @(posedge i_sys_clk);
    ext_pri <= 3'h0;
    apb(1'b1, 8'h00, 32'h0000_0020);
    repeat (4) @(negedge i_sys_clk);
    `CHK("zero outside level", 1'b0, o_cpu_req)
    apb(1'b1, 8'h00, 32'h0000_0000);
    ext_pri <= 3'h5;
    for (int s = 0; s < 12; s++) begin
      apb(1'b1, 8'(en_adr[s]), 32'(1) << en_bit[s]);
      fire_src(s);
      wait_sig(1'b0, 1'b1);
      `CHK("enabled source", 5'(s), o_cpu_src)
      `CHK("outside level", 3'h5, o_cpu_level)
      apb(1'b1, 8'(en_adr[s]), 32'h0000_0000);
      wait_sig(1'b0, 1'b0);
      apb(1'b1, 8'h1c, 32'h0000_0000);
    end
    $display("enable test done");
  endtask
  task automatic t_irq();
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("new request status", 32'h0000_0001, rd)
    apb(1'b1, 8'h20, 32'h0000_0003);
    apb(1'b1, 8'h24, 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped read", 32'h0000_0000, rd)
    wait_sig(1'b1, 1'b1);
    apb(1'b1, 8'h20, 32'h0000_0002);
    wait_sig(1'b1, 1'b0);
    apb(1'b1, 8'h24, 32'h0000_0000);
    apb(1'b1, 8'h02, 32'hffff_ffff);
    `CHK("misaligned error", 1'b1, err)
    repeat (4) @(negedge i_sys_clk);
    `CHK("masked interrupt", 1'b0, o_irq)
    $display("interrupt test done");
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_priority();
    t_enable();
    t_irq();
    give_verdict();
  end
endmodule
